// [xma_core.sv]
// module: extended memory access engine behind the serial register map
`timescale 1ns/1ns
`default_nettype none
module xma_core #(
  parameter int EE_WRITE_CYC = xma_pkg::XMA_EE_WRITE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire xma_pkg::xma_wr_t reg_wr,
  input wire xma_pkg::xma_rd_t reg_rd,
  input wire logic ee_unlocked,
  input wire logic shadow_unlocked,
  input wire logic [31:0] weak_zero,
  input wire logic [31:0] weak_one,
  output logic [15:0] reg_rdata,
  output logic [1:0] reg_rvalid,
  output logic serial_fault_flag_a,
  output logic serial_fault_flag_b,
  output logic interface_fault_flag
);
  import xma_pkg::*;

  // ==========================================================
  // declarations
  xma_wr_t wr_s1_ff, wr_s2_ff;
  xma_rd_t rd_s1_ff, rd_s2_ff;
  logic [7:0] write_adr_ff, read_adr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [31:0] shadow_ff [XMA_WORDS];
  logic [3:0] margin_ff;
  logic wip_ff, wdn_ff, rip_ff, rdn_ff;
  logic warn_xee_ff, err_xee_ff;
  logic [24:0] wcnt_ff;
  logic [4:0] rcnt_ff;
  xma_op_t op_ff;
  logic [31:0] nvm_rdata;
  xma_nvm_req_t nvm_req;
  logic wr_hit_ctl, rd_hit_ctl, start_w, start_r, ctrl_wr;
  logic w_is_ee, w_is_sh, r_is_ee, r_is_sh, w_ok, r_ok;
  logic [15:0] nxt_rdata;

  // ==========================================================
  // synchronise serial front-end strobes
  // two stages: the serial side runs off the host clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_s1_ff <= '0;
      wr_s2_ff <= '0;
      rd_s1_ff <= '0;
      rd_s2_ff <= '0;
    end else begin
      wr_s1_ff <= reg_wr;
      wr_s2_ff <= wr_s1_ff;
      rd_s1_ff <= reg_rd;
      rd_s2_ff <= rd_s1_ff;
    end
  end

  // ==========================================================
  // decode
  assign wr_hit_ctl = wr_s2_ff.valid && wr_s2_ff.be[1];
  assign start_w = wr_hit_ctl && wr_s2_ff.addr == XMA_ADR_WRITE_CTL && wr_s2_ff.data[XMA_BIT_START];
  assign rd_hit_ctl = wr_s2_ff.valid && wr_s2_ff.be[1];
  assign start_r = rd_hit_ctl && wr_s2_ff.addr == XMA_ADR_READ_CTL && wr_s2_ff.data[XMA_BIT_START];
  assign ctrl_wr = wr_s2_ff.valid && wr_s2_ff.addr == XMA_ADR_CTRL;
  assign w_is_ee = write_adr_ff <= XMA_EE_LAST;
  assign w_is_sh = write_adr_ff >= XMA_SH_BASE && write_adr_ff <= XMA_SH_LAST;
  assign r_is_ee = read_adr_ff <= XMA_EE_LAST;
  assign r_is_sh = read_adr_ff >= XMA_SH_BASE && read_adr_ff <= XMA_SH_LAST;
  assign w_ok = (w_is_ee && ee_unlocked) || (w_is_sh && shadow_unlocked);
  // all locations readable without unlock; unmapped ones abort
  assign r_ok = r_is_ee || r_is_sh;

  // ==========================================================
  // host-loaded address and data registers, byte granular
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_adr_ff <= XMA_EE_BASE;
      read_adr_ff <= XMA_EE_BASE;
      wdata_ff <= XMA_ZERO32;
    end else if (wr_s2_ff.valid) begin
      case (wr_s2_ff.addr)
        XMA_ADR_WRITE_ADR: if (wr_s2_ff.be[0]) write_adr_ff <= wr_s2_ff.data[7:0];
        XMA_ADR_READ_ADR: if (wr_s2_ff.be[0]) read_adr_ff <= wr_s2_ff.data[7:0];
        XMA_ADR_WDATA_HI: begin
          if (wr_s2_ff.be[1]) wdata_ff[31:24] <= wr_s2_ff.data[15:8];
          if (wr_s2_ff.be[0]) wdata_ff[23:16] <= wr_s2_ff.data[7:0];
        end
        XMA_ADR_WDATA_LO: begin
          if (wr_s2_ff.be[1]) wdata_ff[15:8] <= wr_s2_ff.data[15:8];
          if (wr_s2_ff.be[0]) wdata_ff[7:0] <= wr_s2_ff.data[7:0];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // margin setting and initiate code
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      margin_ff <= XMA_MARGIN_NORMAL;
    end else begin
      // the code takes effect only when written with the initiate key in the low byte of the same write
      if (ctrl_wr && wr_s2_ff.be[1] && wr_s2_ff.be[0] && wr_s2_ff.data[7:0] == XMA_INIT_MARGIN) begin
        margin_ff <= wr_s2_ff.data[XMA_SPECIAL_LSB +: 4];
      end
    end
  end

  // ==========================================================
  // shadow copies, one generate entry per word
  genvar gi;
  generate
    for (gi = 0; gi < XMA_WORDS; gi++) begin : g_shadow
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          shadow_ff[gi] <= XMA_ZERO32;
        end else if (start_w && op_ff == XMA_OP_IDLE && w_ok && w_is_sh && write_adr_ff[4:0] == 5'(gi)) begin
          shadow_ff[gi] <= wdata_ff;
        end
      end
    end
  endgenerate

  // ==========================================================
  // nonvolatile array
  always_comb begin
    nvm_req.read = (op_ff == XMA_OP_READ);
    nvm_req.write = (op_ff == XMA_OP_WRITE) && wcnt_ff == 25'd1;
    nvm_req.index = (op_ff == XMA_OP_WRITE) ? write_adr_ff[4:0] : read_adr_ff[4:0];
    // check bits in 31:26, 25:24 never stored
    nvm_req.wdata = {wdata_ff[31:26], 2'b00, wdata_ff[23:0]};
    nvm_req.margin = margin_ff;
  end

  xma_nvm_cell u_nvm (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(nvm_req),
    .weak_zero(weak_zero),
    .weak_one(weak_one),
    .rdata(nvm_rdata)
  );

  // ==========================================================
  // access sequencer; starts while busy are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_ff <= XMA_OP_IDLE;
      wcnt_ff <= '0;
      rcnt_ff <= '0;
    end else begin
      case (op_ff)
        XMA_OP_IDLE: begin
          if (start_w && w_ok && w_is_ee) begin
            op_ff <= XMA_OP_WRITE;
            wcnt_ff <= 25'(EE_WRITE_CYC);
          end else if (start_r && r_ok && r_is_ee) begin
            op_ff <= XMA_OP_READ;
            rcnt_ff <= 5'(XMA_EE_READ_CYC);
          end
        end
        XMA_OP_WRITE: begin
          wcnt_ff <= wcnt_ff - 25'd1;
          if (wcnt_ff == 25'd1) op_ff <= XMA_OP_IDLE;
        end
        XMA_OP_READ: begin
          rcnt_ff <= rcnt_ff - 5'd1;
          if (rcnt_ff == 5'd1) op_ff <= XMA_OP_IDLE;
        end
        default: op_ff <= XMA_OP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // write progress and done flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wip_ff <= 1'b0;
      wdn_ff <= 1'b0;
    end else if (op_ff == XMA_OP_WRITE) begin
      if (wcnt_ff == 25'd1) begin
        wip_ff <= 1'b0;
        wdn_ff <= 1'b1;
      end
    end else if (start_w && op_ff == XMA_OP_IDLE) begin
      // shadow or aborted writes finish at once
      wip_ff <= w_ok && w_is_ee;
      wdn_ff <= !(w_ok && w_is_ee);
    end
  end

  // ==========================================================
  // read progress, done flags and read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rip_ff <= 1'b0;
      rdn_ff <= 1'b0;
      rdata_ff <= XMA_ZERO32;
    end else if (op_ff == XMA_OP_READ) begin
      if (rcnt_ff == 5'd1) begin
        rip_ff <= 1'b0;
        rdn_ff <= 1'b1;
        rdata_ff <= nvm_rdata;
      end
    end else if (start_r && op_ff == XMA_OP_IDLE) begin
      rip_ff <= r_ok && r_is_ee;
      rdn_ff <= !(r_ok && r_is_ee);
      if (r_ok && r_is_sh) rdata_ff <= shadow_ff[read_adr_ff[4:0]];
    end
  end

  // ==========================================================
  // access warning and error bits; a new abort wins over a clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      warn_xee_ff <= 1'b0;
      err_xee_ff <= 1'b0;
    end else begin
      if (op_ff == XMA_OP_IDLE && ((start_w && !w_ok) || (start_r && !r_ok))) begin
        warn_xee_ff <= 1'b1;
      end else if (ctrl_wr && wr_s2_ff.be[1] && wr_s2_ff.data[XMA_BIT_CLR_WARN]) begin
        warn_xee_ff <= 1'b0;
      end
      if (op_ff == XMA_OP_IDLE && start_w && !w_ok && w_is_ee) begin
        err_xee_ff <= 1'b1;
      end else if (ctrl_wr && wr_s2_ff.be[1] && wr_s2_ff.data[XMA_BIT_CLR_ERR]) begin
        err_xee_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read-back mux; start bits always read zero
  always_comb begin
    nxt_rdata = XMA_ZERO16;
    case (rd_s2_ff.addr)
      XMA_ADR_WRITE_ADR: nxt_rdata = {8'h00, write_adr_ff};
      XMA_ADR_WDATA_HI: nxt_rdata = wdata_ff[31:16];
      XMA_ADR_WDATA_LO: nxt_rdata = wdata_ff[15:0];
      XMA_ADR_WRITE_CTL: nxt_rdata = {7'h00, wip_ff, 7'h00, wdn_ff};
      XMA_ADR_READ_ADR: nxt_rdata = {8'h00, read_adr_ff};
      XMA_ADR_READ_CTL: nxt_rdata = {7'h00, rip_ff, 7'h00, rdn_ff};
      XMA_ADR_RDATA_HI: nxt_rdata = rdata_ff[31:16];
      XMA_ADR_RDATA_LO: nxt_rdata = rdata_ff[15:0];
      XMA_ADR_CTRL: nxt_rdata = {margin_ff, 12'h000};
      XMA_ADR_ERR: nxt_rdata = {15'h0000, err_xee_ff};
      XMA_ADR_WARN: nxt_rdata = {15'h0000, warn_xee_ff};
      default: nxt_rdata = XMA_ZERO16;
    endcase
  end

  // answer pipelined: a new read strobe may arrive every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= XMA_ZERO16;
      reg_rvalid <= 2'b00;
    end else begin
      reg_rdata <= nxt_rdata;
      reg_rvalid <= {rd_s2_ff.valid, rd_s2_ff.valid};
    end
  end

  // ==========================================================
  // fault flags for the outer error register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serial_fault_flag_a <= 1'b0;
      serial_fault_flag_b <= 1'b0;
      interface_fault_flag <= 1'b0;
    end else begin
      serial_fault_flag_a <= err_xee_ff;
      serial_fault_flag_b <= warn_xee_ff;
      // start while busy is dropped; flag it
      interface_fault_flag <= (start_w || start_r) && op_ff != XMA_OP_IDLE;
    end
  end
endmodule // xma_core
`default_nettype wire

// [xma_core_props.sv]
// port assertions for the extended memory access engine
`timescale 1ns/1ns
`default_nettype none
module xma_core_props
  import xma_pkg::*;
#(
  parameter int EE_WRITE_CYC = XMA_EE_WRITE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire xma_wr_t reg_wr,
  input wire xma_rd_t reg_rd,
  input wire logic ee_unlocked,
  input wire logic shadow_unlocked,
  input wire logic [31:0] weak_zero,
  input wire logic [31:0] weak_one,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] reg_rvalid,
  input wire logic serial_fault_flag_a,
  input wire logic serial_fault_flag_b,
  input wire logic interface_fault_flag
);
  // ==========================================================
  // helper ages: cycles since the last clear or start request
  logic [3:0] clr_age_ff;
  logic [3:0] start_age_ff;
  logic clr_req;
  logic start_req;
  assign clr_req = reg_wr.valid && reg_wr.addr == XMA_ADR_CTRL && reg_wr.be[1] && reg_wr.data[XMA_BIT_CLR_ERR];
  assign start_req = reg_wr.valid && reg_wr.be[1] && reg_wr.data[XMA_BIT_START] &&
    (reg_wr.addr == XMA_ADR_WRITE_CTL || reg_wr.addr == XMA_ADR_READ_CTL);
  // reset counts as a clear, so a flag dropping under reset is legal
  always_ff @(posedge clk_sys) begin
    if (rst || clr_req) clr_age_ff <= 4'h0;
    else if (clr_age_ff != 4'hF) clr_age_ff <= clr_age_ff + 4'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) start_age_ff <= 4'hF;
    else if (start_req) start_age_ff <= 4'h0;
    else if (start_age_ff != 4'hF) start_age_ff <= start_age_ff + 4'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_read(logic [7:0] a);
    reg_rd.valid && reg_rd.addr == a;
  endsequence
  sequence s_answer;
    reg_rvalid == 2'b11;
  endsequence
  chk_read_answered: assert property (reg_rd.valid |-> ##3 s_answer)
    else $error("read strobe not answered in three cycles");
  chk_answer_cause: assert property (reg_rvalid != 2'b00 |-> $past(reg_rd.valid, 3))
    else $error("answer without a read strobe");
  chk_rvalid_pairs: assert property (reg_rvalid != 2'b01 && reg_rvalid != 2'b10)
    else $error("answer valid bits split");
  chk_status_reserved: assert property ((s_read(XMA_ADR_WRITE_CTL) or s_read(XMA_ADR_READ_CTL))
    |-> ##3 (reg_rdata & 16'hFEFE) == 16'h0000) else $error("status read shows start or reserved bits");
  chk_ctrl_readback: assert property (s_read(XMA_ADR_CTRL) |-> ##3 reg_rdata[11:0] == 12'h000)
    else $error("control readback low bits not zero");
  chk_unmapped_zero: assert property (s_read(8'h40) |-> ##3 reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=> reg_rvalid == 2'b00 && !serial_fault_flag_a
    && !serial_fault_flag_b && !interface_fault_flag) else $error("outputs active after reset edge");
  chk_err_with_warn: assert property ($rose(serial_fault_flag_a) |-> serial_fault_flag_b)
    else $error("error access bit without warning bit");
  chk_err_clear_cause: assert property ($fell(serial_fault_flag_a) |-> clr_age_ff <= 4'h6)
    else $error("error access bit dropped without clear");
  chk_busy_refusal: assert property (interface_fault_flag |-> start_age_ff >= 4'h2 && start_age_ff <= 4'h5)
    else $error("refusal pulse without a start request");
endmodule // xma_core_props
bind xma_core xma_core_props #(.EE_WRITE_CYC(EE_WRITE_CYC)) u_props (
  .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .ee_unlocked(ee_unlocked),
  .shadow_unlocked(shadow_unlocked), .weak_zero(weak_zero), .weak_one(weak_one), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .serial_fault_flag_a(serial_fault_flag_a), .serial_fault_flag_b(serial_fault_flag_b),
  .interface_fault_flag(interface_fault_flag));
`default_nettype wire

// [xma_core_test.sv]
// self-checking testbench for the extended memory access engine
`timescale 1ns/1ns
`default_nettype none
module xma_core_test;
  import xma_pkg::*;
  localparam logic [3:0] MCODE [4] = '{XMA_MARGIN_NORMAL, XMA_MARGIN_LOW, XMA_MARGIN_HIGH, XMA_MARGIN_NORMAL};
  localparam logic [15:0] MLO [4] = '{16'h5678, 16'h5679, 16'h5670, 16'h5678};
  logic clk_sys, rst, ee_unlocked, shadow_unlocked, serial_fault_flag_a, serial_fault_flag_b, interface_fault_flag;
  xma_wr_t reg_wr;
  xma_rd_t reg_rd;
  logic [31:0] weak_zero, weak_one, rnd, ent;
  logic [15:0] reg_rdata, last_rdata;
  logic [1:0] reg_rvalid;
  logic [7:0] xa;
  logic [31:0] exp_q[$];
  int n_errors, n_compared, n_ans, fault_seen, seed;
  xma_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd));
  xma_core #(.EE_WRITE_CYC(10)) uut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .ee_unlocked(ee_unlocked), .shadow_unlocked(shadow_unlocked), .weak_zero(weak_zero), .weak_one(weak_one),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .serial_fault_flag_a(serial_fault_flag_a),
    .serial_fault_flag_b(serial_fault_flag_b), .interface_fault_flag(interface_fault_flag));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // checking and reporting
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail_now();
    n_errors++;
    $display("ERROR %0t wait ran out or answer unexpected", $time);
    report_and_stop();
  endtask
  task automatic compare_word(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
    if (mask !== 16'h0000) begin
      n_compared++;
      if ((got & mask) !== (exp & mask)) begin
        n_errors++;
        $display("ERROR %0t read %h expected %h mask %h", $time, got, exp, mask);
      end
    end
  endtask
  task automatic compare_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // answers come back in request order, so the oldest note matches
  always @(negedge clk_sys) begin
    if (interface_fault_flag === 1'b1) fault_seen++;
    if (reg_rvalid === 2'b11) begin
      last_rdata = reg_rdata;
      n_ans++;
      if (exp_q.size() == 0) fail_now();
      ent = exp_q.pop_front();
      compare_word(reg_rdata, ent[15:0], ent[31:16]);
    end
  end
  // ==========================================================
  // requests
  task automatic rd_exp(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] mask);
    exp_q.push_back({mask, exp});
    host.rd(a);
  endtask
  task automatic settle();
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk_sys);
    if (exp_q.size() != 0) fail_now();
  endtask
  // poll a status register until its done bit reads one
  task automatic poll_done(input logic [7:0] a);
    int k;
    for (int i = 0; i < 40; i++) begin
      settle();
      k = n_ans;
      exp_q.push_back(32'h0);
      host.rd(a);
      for (int j = 0; j < 8 && n_ans == k; j++) @(negedge clk_sys);
      if (n_ans == k) fail_now();
      if (last_rdata[XMA_BIT_DONE] === 1'b1) return;
    end
    fail_now();
  endtask
  task automatic wait_flags();
    settle();
    repeat (6) @(negedge clk_sys);
  endtask
  initial begin
    {n_errors, n_compared, n_ans, fault_seen} = '0;
    seed = 23796;
    rst = 1'b1;
    ee_unlocked = 1'b1; // key sequence lives outside; unlock is a level here
    shadow_unlocked = 1'b1;
    weak_zero = 32'h00000001;
    weak_one = 32'h00000008;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd_exp(XMA_ADR_WRITE_CTL, 16'h0000, 16'hFFFF);
    rd_exp(XMA_ADR_CTRL, 16'h0000, 16'hFFFF);
    rd_exp(8'h40, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 2; i++) begin
      rnd = $random(seed);
      xa = (i == 0) ? XMA_SH_BASE : XMA_SH_LAST;
      host.ext_write(xa, rnd);
      rd_exp(XMA_ADR_WRITE_CTL, 16'h0001, 16'hFFFF);
      host.ext_read(xa);
      rd_exp(XMA_ADR_READ_CTL, 16'h0001, 16'hFFFF);
      rd_exp(XMA_ADR_RDATA_HI, rnd[31:16], 16'hFFFF);
      rd_exp(XMA_ADR_RDATA_LO, rnd[15:0], 16'hFFFF);
    end
    // bits 25:24 set on purpose: the array must store them as zero
    host.ext_write(XMA_EE_LAST, 32'hFFA45678);
    rd_exp(XMA_ADR_WRITE_CTL, 16'h0100, 16'hFFFF);
    poll_done(XMA_ADR_WRITE_CTL);
    for (int m = 0; m < 4; m++) begin
      host.wr(XMA_ADR_CTRL, {MCODE[m], 4'h0, XMA_INIT_MARGIN}, 2'b11);
      host.wr(XMA_ADR_CTRL, 16'h3000, 2'b11);
      rd_exp(XMA_ADR_CTRL, {MCODE[m], 12'h000}, 16'hFFFF);
      host.ext_read(XMA_EE_LAST);
      rd_exp(XMA_ADR_READ_CTL, 16'h0100, 16'hFFFF);
      poll_done(XMA_ADR_READ_CTL);
      rd_exp(XMA_ADR_RDATA_HI, 16'hFCA4, 16'hFFFF);
      rd_exp(XMA_ADR_RDATA_LO, MLO[m], 16'hFFFF);
    end
    // a start while the array is busy is dropped
    host.ext_write(XMA_EE_BASE, 32'h00000000);
    host.wr(XMA_ADR_READ_CTL, 16'h8000, 2'b10);
    poll_done(XMA_ADR_WRITE_CTL);
    compare_bit(fault_seen > 0, 1'b1);
    @(posedge clk_sys);
    ee_unlocked <= 1'b0;
    host.ext_write(XMA_EE_BASE, rnd);
    poll_done(XMA_ADR_WRITE_CTL);
    wait_flags();
    compare_bit(serial_fault_flag_a, 1'b1);
    compare_bit(serial_fault_flag_b, 1'b1);
    rd_exp(XMA_ADR_ERR, 16'h0001, 16'h0001);
    rd_exp(XMA_ADR_WARN, 16'h0001, 16'h0001);
    host.wr(XMA_ADR_CTRL, 16'h0300, 2'b10);
    wait_flags();
    compare_bit(serial_fault_flag_a | serial_fault_flag_b, 1'b0);
    @(posedge clk_sys);
    shadow_unlocked <= 1'b0;
    host.ext_write(XMA_SH_BASE, rnd);
    poll_done(XMA_ADR_WRITE_CTL);
    wait_flags();
    compare_bit(serial_fault_flag_b, 1'b1);
    compare_bit(serial_fault_flag_a, 1'b0);
    settle();
    report_and_stop();
  end
endmodule // xma_core_test
`default_nettype wire

// [xma_host.sv]
// host model: register writes and read strobes of the serial front end
`timescale 1ns/1ns
`default_nettype none
module xma_host (
  input wire logic clk_sys,
  output var xma_pkg::xma_wr_t reg_wr,
  output var xma_pkg::xma_rd_t reg_rd
);
  import xma_pkg::*;
  initial begin
    reg_wr = '0;
    reg_rd = '0;
  end
  // ==========================================================
  // one-cycle strobes, a free edge between two requests
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_sys);
    reg_wr <= '{1'b1, a, d, be};
    @(posedge clk_sys);
    reg_wr.valid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= '{1'b1, a};
    @(posedge clk_sys);
    reg_rd.valid <= 1'b0;
  endtask
  // address first, whole 32-bit word, then start
  task automatic ext_write(input logic [7:0] xa, input logic [31:0] d);
    wr(XMA_ADR_WRITE_ADR, {8'h00, xa}, 2'b01);
    wr(XMA_ADR_WDATA_HI, d[31:16], 2'b11);
    wr(XMA_ADR_WDATA_LO, d[15:0], 2'b11);
    wr(XMA_ADR_WRITE_CTL, 16'h8000, 2'b10);
  endtask
  task automatic ext_read(input logic [7:0] xa);
    wr(XMA_ADR_READ_ADR, {8'h00, xa}, 2'b01);
    wr(XMA_ADR_READ_CTL, 16'h8000, 2'b10);
  endtask
endmodule // xma_host
`default_nettype wire

// [xma_nvm_cell.sv]
// module: nonvolatile word array model with margin read threshold
`timescale 1ns/1ns
`default_nettype none
module xma_nvm_cell (
  input wire logic clk_sys,
  input wire logic rst,
  input wire xma_pkg::xma_nvm_req_t req,
  input wire logic [31:0] weak_zero,
  input wire logic [31:0] weak_one,
  output logic [31:0] rdata
);
  import xma_pkg::*;

  logic [31:0] word_ff [XMA_WORDS];
  logic [31:0] stored;

  // ==========================================================
  // storage, one generate entry per word
  genvar gi;
  generate
    for (gi = 0; gi < XMA_WORDS; gi++) begin : g_word
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          word_ff[gi] <= XMA_ZERO32;
        end else if (req.write && req.index == 5'(gi)) begin
          word_ff[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // threshold shifted read
  // weak cells sit near the threshold; margin reads expose them
  always_comb begin
    stored = word_ff[req.index];
    case (req.margin)
      XMA_MARGIN_LOW: rdata = stored | weak_zero;
      XMA_MARGIN_HIGH: rdata = stored & ~weak_one;
      default: rdata = stored;
    endcase
  end
endmodule // xma_nvm_cell
`default_nettype wire

// [xma_pkg.sv]
// package: register map, field positions, codes and timing for extended memory access
package xma_pkg;
  // serial register byte addresses
  localparam logic [7:0] XMA_ADR_WRITE_ADR = 8'h02;
  localparam logic [7:0] XMA_ADR_WDATA_HI = 8'h04;
  localparam logic [7:0] XMA_ADR_WDATA_LO = 8'h06;
  localparam logic [7:0] XMA_ADR_WRITE_CTL = 8'h08;
  localparam logic [7:0] XMA_ADR_READ_ADR = 8'h0A;
  localparam logic [7:0] XMA_ADR_READ_CTL = 8'h0C;
  localparam logic [7:0] XMA_ADR_RDATA_HI = 8'h0E;
  localparam logic [7:0] XMA_ADR_RDATA_LO = 8'h10;
  localparam logic [7:0] XMA_ADR_CTRL = 8'h1E;
  localparam logic [7:0] XMA_ADR_ERR = 8'h24;
  localparam logic [7:0] XMA_ADR_WARN = 8'h26;
  // field positions inside a 16-bit register
  localparam int XMA_BIT_START = 15;
  localparam int XMA_BIT_BUSY = 8;
  localparam int XMA_BIT_DONE = 0;
  localparam int XMA_BIT_CLR_ERR = 8;
  localparam int XMA_BIT_CLR_WARN = 9;
  localparam int XMA_BIT_XEE = 0;
  localparam int XMA_SPECIAL_LSB = 12;
  // extended address space
  localparam logic [7:0] XMA_EE_BASE = 8'h00;
  localparam logic [7:0] XMA_EE_LAST = 8'h1F;
  localparam logic [7:0] XMA_SH_BASE = 8'h40;
  localparam logic [7:0] XMA_SH_LAST = 8'h5F;
  localparam int XMA_WORDS = 32;
  // codes
  localparam logic [3:0] XMA_MARGIN_NORMAL = 4'h0;
  localparam logic [3:0] XMA_MARGIN_LOW = 4'h1;
  localparam logic [3:0] XMA_MARGIN_HIGH = 4'h2;
  localparam logic [7:0] XMA_INIT_MARGIN = 8'hA5;
  // timing at the 10 MHz system clock
  localparam int XMA_CLK_NS = 100;
  localparam int XMA_EE_WRITE_MS = 24;
  localparam int XMA_EE_READ_US = 2;
  localparam int XMA_EE_WRITE_CYC = XMA_EE_WRITE_MS * 1000000 / XMA_CLK_NS;
  localparam int XMA_EE_READ_CYC = XMA_EE_READ_US * 1000 / XMA_CLK_NS;
  localparam logic [15:0] XMA_ZERO16 = 16'h0000;
  localparam logic [31:0] XMA_ZERO32 = 32'h00000000;

  // one decoded register write from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
    logic [1:0]  be; // be[1] high byte at addr, be[0] low byte at addr+1
  } xma_wr_t;

  // one read strobe from the serial front end
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } xma_rd_t;

  // request to the nonvolatile array
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  index;
    logic [31:0] wdata;
    logic [3:0]  margin;
  } xma_nvm_req_t;

  typedef enum logic [1:0] {XMA_OP_IDLE, XMA_OP_READ, XMA_OP_WRITE} xma_op_t;
endpackage : xma_pkg
